// file: bench/adc_warmup_asserts.sv
// Assertions for the warm-up and ready interrupt block
`timescale 1ns/10ps
`default_nettype none
module adc_warmup_asserts (
  input wire logic clk_sys, // Clock
  input wire logic rst, // Reset
  input wire logic [3:0] addr, // Index
  input wire logic [15:0] wr_data, // Write data
  input wire logic wr_en, // Write strobe
  input wire logic rd_en, // Read strobe
  input wire logic [15:0] rd_data, // Read data
  input wire logic irq, // Interrupt
  input wire logic [4:0] core_power, // Power enables
  input wire logic [39:0] sample_time // Sample times
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  core_hi_zero_a: assert property (rd_en && addr[3:2] == 2'b10 |=>
    rd_data[15:10] == 6'h00) else $error("core register upper bits not zero");
  samp_wr_a: assert property (wr_en && addr == 4'h8 |=>
    sample_time[9:0] == $past(wr_data[9:0])) else $error("sample time write lost");
  samp_rd_a: assert property (rd_en && addr == 4'hB |=>
    rd_data[9:0] == sample_time[39:30]) else $error("sample time read mismatch");
  pwr_wr_a: assert property (wr_en && addr == 4'h1 |=>
    core_power == {$past(wr_data[7]), $past(wr_data[3:0])}) else $error("power write lost");
  pwr_rd_a: assert property (rd_en && addr == 4'h1 |=>
    rd_data == {8'h00, core_power[4], 3'h0, core_power[3:0]}) else $error("power read mismatch");
  ctl_rsvd_a: assert property (rd_en && addr == 4'h0 |=>
    !(|rd_data[15:12]) && !(|rd_data[6:4])) else $error("warm-up register spare bits set");
  mask_off_a: assert property (wr_en && addr == 4'h4 && wr_data == 16'h0000 |=> !irq)
    else $error("interrupt despite empty mask");
  irq_cause_a: assert property ($rose(irq) && !$past(wr_en) && !$past(wr_en, 2) |->
    core_power != 5'h00) else $error("interrupt with no core powered");
  cover property ($rose(irq));
  cover property (wr_en && addr == 4'h3);
  cover property (rd_en && addr == 4'h2 ##1 rd_data != 16'h0000);
endmodule
bind adc_core_warmup_ready_irq adc_warmup_asserts u_adc_warmup_asserts (.clk_sys(clk_sys),
  .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
  .irq(irq), .core_power(core_power), .sample_time(sample_time));
`default_nettype wire

// file: bench/testbench.sv
// Register-level bench for the warm-up and ready interrupt block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk_sys, rst, wr_en, rd_en, irq;
  logic [3:0] addr;
  logic [15:0] wr_data, rd_data;
  logic [4:0] core_power;
  logic [39:0] sample_time;
  int n_mismatch = 0;
  int tests_run = 0;
  int n;
  adc_core_warmup_ready_irq #(.WARMUP_DIV_LOG2(8)) u_adc_core_warmup_ready_irq (.clk_sys(clk_sys),
    .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .irq(irq), .core_power(core_power), .sample_time(sample_time));
  task report_and_stop;
    if (n_mismatch == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_sys);
    addr <= a;
    wr_data <= v;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1 chk(rd_data, exp);
  endtask
  // Cycles from power write edge until interrupt seen
  task wait_irq(output int k);
    k = 0;
    do begin
      @(posedge clk_sys);
      #1 k++;
    end while (irq !== 1'b1 && k < 400);
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    rst = 1'b1;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 4'h0;
    wr_data = 16'h0000;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 12; i++) rd(i[3:0], 16'h0000);
    for (int i = 0; i < 4; i++) begin
      wr(4'h8 + i[3:0], 16'hFFF0 + 16'(i));
      rd(4'h8 + i[3:0], 16'h03F0 + 16'(i));
      chk({6'h00, sample_time[10*i +: 10]}, 16'h03F0 + 16'(i));
    end
    wr(4'h5, 16'hFFFF);
    rd(4'h5, 16'h0000);
    wr(4'h4, 16'h009F);
    for (int c = 9; c < 16; c += 3) begin
      wr(4'h0, {4'h0, c[3:0], 8'h8F});
      wr(4'h1, 16'h0001);
      wait_irq(n);
      chk(16'(n), 16'((1 << c) >> 8) + 16'h0001);
      chk({11'h000, core_power}, 16'h0001);
      rd(4'h2, 16'h0001);
      wr(4'h1, 16'h0000);
      wr(4'h3, 16'h009F);
      rd(4'h2, 16'h0000);
      rd(4'h3, 16'h0000);
      chk({15'h0000, irq}, 16'h0000);
    end
    wr(4'h0, 16'h0907);
    wr(4'h1, 16'h0008);
    repeat (10) @(posedge clk_sys);
    rd(4'h2, 16'h0008);
    rd(4'h3, 16'h0000);
    chk({15'h0000, irq}, 16'h0000);
    wr(4'h4, 16'h0000);
    wr(4'h0, 16'h0980);
    wr(4'h1, 16'h0080);
    repeat (10) @(posedge clk_sys);
    rd(4'h3, 16'h0080);
    chk({15'h0000, irq}, 16'h0000);
    wr(4'h4, 16'h0080);
    #1 chk({15'h0000, irq}, 16'h0001);
    wr(4'h3, 16'h0080);
    rd(4'h3, 16'h0000);
    chk({15'h0000, irq}, 16'h0000);
    report_and_stop;
  end
  initial begin
    #(50 * 3000);
    n_mismatch++;
    report_and_stop;
  end
endmodule
`default_nettype wire

// file: logic/adc_core_warmup_ready_irq.sv
// Converter core warm-up delay, ready interrupt and core control registers
// Overview of operation
// - Warm-up code selects two-power source clock count
// - Each core has its own ready interrupt enable
// - Cleared enable blocks that core's ready interrupt
// - Four core registers with 10-bit sample time
// - Core register bits 15 to 10 read zero
// - Power enable bit per core; off clears ready
`timescale 1ns/10ps
`default_nettype none
module adc_core_warmup_ready_irq #(
  parameter int WARMUP_DIV_LOG2 = 0
) (
  input wire logic clk_sys, // System clock, 20 MHz
  input wire logic rst, // Asynchronous reset, active high
  input wire logic [adc_warmup_pkg::ADDR_W-1:0] addr, // Register index
  input wire logic [adc_warmup_pkg::DATA_W-1:0] wr_data, // Write data
  input wire logic wr_en, // Write strobe
  input wire logic rd_en, // Read strobe
  output logic [adc_warmup_pkg::DATA_W-1:0] rd_data, // Read data, cycle after strobe
  output logic irq, // Common interrupt, level
  output logic [adc_warmup_pkg::NUM_UNITS-1:0] core_power, // Power enables
  output logic [adc_warmup_pkg::NUM_CORES*adc_warmup_pkg::SAMPLE_TIME_W-1:0] sample_time
    // Sample time per core, core 0 in low bits
);
  localparam int NU = adc_warmup_pkg::NUM_UNITS;
  localparam int NC = adc_warmup_pkg::NUM_CORES;
  localparam int SW = adc_warmup_pkg::SAMPLE_TIME_W;

  logic [adc_warmup_pkg::WARMUP_SEL_W-1:0] warmup_sel_reg, warmup_sel_next;
  logic [NU-1:0] irq_en_reg, irq_en_next;
  logic [NU-1:0] power_reg, power_next;
  logic [NU-1:0] status_reg, status_next;
  logic [NU-1:0] mask_reg, mask_next;
  logic [SW-1:0] samp_reg [NC];
  logic [SW-1:0] samp_next [NC];
  logic [adc_warmup_pkg::DATA_W-1:0] rd_data_reg, rd_data_next;
  logic irq_reg, irq_next;
  logic [NU-1:0] wr_units;
  logic [31:0] delay_full;
  logic [15:0] delay_val;

  core_warmup_if #(.N(NU)) wu ();

  // Unit vector: cores in bits 3:0, shared core in bit 7
  function automatic logic [15:0] pack_units(input logic [NU-1:0] v);
    pack_units = {8'h00, v[NU-1], 3'h0, v[NC-1:0]};
  endfunction

  genvar g;
  generate
    for (g = 0; g < NU; g++) begin : g_timer
      core_warmup_timer #(.IDX(g)) u_timer (
        .clk_sys(clk_sys),
        .rst(rst),
        .wu(wu)
      );
    end
  endgenerate

  // Delay of 2^code periods, optionally scaled down for simulation
  always_comb begin
    delay_full = (32'h0000_0001 << warmup_sel_reg) >> WARMUP_DIV_LOG2;
    delay_val = (delay_full == 32'h0000_0000) ? 16'h0001 : delay_full[15:0];
  end

  assign wu.delay = delay_val;
  assign wu.power = power_reg;

  assign wr_units = {wr_data[adc_warmup_pkg::SHARED_BIT], wr_data[NC-1:0]};

  // Configuration group: warm-up code, ready enables, power, mask
  always_comb begin
    warmup_sel_next = warmup_sel_reg;
    irq_en_next = irq_en_reg;
    power_next = power_reg;
    mask_next = mask_reg;
    if (wr_en) begin
      unique case (addr)
        adc_warmup_pkg::OFS_WARMUP_IRQ_EN: begin
          warmup_sel_next = wr_data[adc_warmup_pkg::WARMUP_SEL_LSB +:
                                    adc_warmup_pkg::WARMUP_SEL_W];
          irq_en_next = wr_units;
        end
        adc_warmup_pkg::OFS_POWER: power_next = wr_units;
        adc_warmup_pkg::OFS_IRQ_MASK: mask_next = wr_units;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      warmup_sel_reg <= adc_warmup_pkg::WARMUP_SEL_RST;
      irq_en_reg <= adc_warmup_pkg::UNIT_BITS_RST;
      power_reg <= adc_warmup_pkg::UNIT_BITS_RST;
      mask_reg <= adc_warmup_pkg::UNIT_BITS_RST;
    end else begin
      warmup_sel_reg <= warmup_sel_next;
      irq_en_reg <= irq_en_next;
      power_reg <= power_next;
      mask_reg <= mask_next;
    end
  end

  // Status group: ready events set, write one clears; set wins
  always_comb begin
    status_next = status_reg;
    if (wr_en && (addr == adc_warmup_pkg::OFS_IRQ_STATUS)) begin
      status_next = status_reg & ~wr_units;
    end
    status_next = status_next | (wu.ready_event & irq_en_reg);
    irq_next = |(status_next & mask_next);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      status_reg <= adc_warmup_pkg::UNIT_BITS_RST;
      irq_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      irq_reg <= irq_next;
    end
  end

  // Sample time group, one field per core
  always_comb begin
    for (int i = 0; i < NC; i++) begin
      samp_next[i] = samp_reg[i];
      if (wr_en && (addr == adc_warmup_pkg::OFS_CORE_CTL_BASE + 4'(i))) begin
        samp_next[i] = wr_data[SW-1:0];
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NC; i++) begin
        samp_reg[i] <= adc_warmup_pkg::SAMPLE_TIME_RST;
      end
    end else begin
      for (int i = 0; i < NC; i++) begin
        samp_reg[i] <= samp_next[i];
      end
    end
  end

  always_comb begin
    rd_data_next = adc_warmup_pkg::RD_DATA_RST;
    if (rd_en) begin
      unique case (addr)
        adc_warmup_pkg::OFS_WARMUP_IRQ_EN: begin
          rd_data_next = pack_units(irq_en_reg);
          rd_data_next[adc_warmup_pkg::WARMUP_SEL_LSB +:
                       adc_warmup_pkg::WARMUP_SEL_W] = warmup_sel_reg;
        end
        adc_warmup_pkg::OFS_POWER: rd_data_next = pack_units(power_reg);
        adc_warmup_pkg::OFS_READY: rd_data_next = pack_units(wu.ready);
        adc_warmup_pkg::OFS_IRQ_STATUS: rd_data_next = pack_units(status_reg);
        adc_warmup_pkg::OFS_IRQ_MASK: rd_data_next = pack_units(mask_reg);
        default: begin
          for (int i = 0; i < NC; i++) begin
            if (addr == adc_warmup_pkg::OFS_CORE_CTL_BASE + 4'(i)) begin
              rd_data_next = {6'h00, samp_reg[i]};
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_data_reg <= adc_warmup_pkg::RD_DATA_RST;
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end

  generate
    for (g = 0; g < NC; g++) begin : g_samp_out
      assign sample_time[g*SW +: SW] = samp_reg[g];
    end
  endgenerate

  assign rd_data = rd_data_reg;
  assign irq = irq_reg;
  assign core_power = power_reg;
endmodule
`default_nettype wire

// file: logic/adc_warmup_pkg.sv
// Shared constants for the converter core warm-up and ready interrupt block
package adc_warmup_pkg;
  localparam int NUM_CORES = 4;
  localparam int NUM_UNITS = NUM_CORES + 1;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int CNT_W = 16;
  localparam int SAMPLE_TIME_W = 10;
  localparam int WARMUP_SEL_W = 4;
  localparam int WARMUP_SEL_LSB = 8;
  localparam int SHARED_BIT = 7;
  localparam logic [ADDR_W-1:0] OFS_WARMUP_IRQ_EN = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_POWER = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_READY = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_CORE_CTL_BASE = 4'h8;
  localparam logic [WARMUP_SEL_W-1:0] WARMUP_SEL_RST = 4'h0;
  localparam logic [NUM_UNITS-1:0] UNIT_BITS_RST = 5'h00;
  localparam logic [SAMPLE_TIME_W-1:0] SAMPLE_TIME_RST = 10'h000;
  localparam logic [DATA_W-1:0] RD_DATA_RST = 16'h0000;
endpackage

// file: logic/core_warmup_if.sv
// Carrier between the control block and the per-core warm-up timers
`timescale 1ns/10ps
`default_nettype none
interface core_warmup_if #(parameter int N = 5);
  logic [15:0] delay;
  logic [N-1:0] power;
  logic [N-1:0] ready;
  logic [N-1:0] ready_event;
  modport ctrl(output delay, output power, input ready, input ready_event);
  modport timer(input delay, input power, output ready, output ready_event);
endinterface
`default_nettype wire

// file: logic/core_warmup_timer.sv
// Warm-up counter for one converter core
`timescale 1ns/10ps
`default_nettype none
module core_warmup_timer #(
  parameter int IDX = 0
) (
  input wire logic clk_sys, // System clock
  input wire logic rst, // Asynchronous reset, active high
  core_warmup_if.timer wu // Delay, power in; ready out
);
  logic [adc_warmup_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  logic ready_reg, ready_next;
  logic event_reg, event_next;
  logic [adc_warmup_pkg::CNT_W-1:0] cnt_inc;

  always_comb begin
    cnt_inc = cnt_reg + 16'h0001;
    cnt_next = cnt_reg;
    ready_next = ready_reg;
    event_next = 1'b0;
    if (!wu.power[IDX]) begin
      cnt_next = '0;
      ready_next = 1'b0;
    end else if (!ready_reg) begin
      if (cnt_inc >= wu.delay) begin
        ready_next = 1'b1;
        event_next = 1'b1;
      end else begin
        cnt_next = cnt_inc;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
      ready_reg <= 1'b0;
      event_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      ready_reg <= ready_next;
      event_reg <= event_next;
    end
  end

  assign wu.ready[IDX] = ready_reg;
  assign wu.ready_event[IDX] = event_reg;
endmodule
`default_nettype wire
